// *** src/fsr_cfg.svh ***
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
// ==========================================================
// Register indices; byte address is four times the index
`define FSR_IDX_CMD    6'h00
`define FSR_IDX_STAT   6'h01
`define FSR_IDX_CFG    6'h02
`define FSR_IDX_RSVD   6'h05
`define FSR_IDX_MODE   6'h07
`define FSR_IDX_SDATA  6'h0a
`define FSR_IDX_SSTAT  6'h0b
`define FSR_IDX_SCTL   6'h0c
`define FSR_IDX_UTIL2  6'h10
// ==========================================================
// Field positions
`define FSR_CMD_RST_BIT   0
`define FSR_CMD_CLR_BIT   4
`define FSR_CMD_READBACK  8'h02
`define FSR_ST_UNDER_BIT  0
`define FSR_ST_FV_BIT     1
`define FSR_ST_FIFO_BIT   4
`define FSR_CFG_CLR_BIT   3
`define FSR_SS_RXRDY_BIT  0
`define FSR_SS_TXRDY_BIT  1
`define FSR_SS_FVIRQ_BIT  4
`define FSR_SS_FVLAT_BIT  6
`define FSR_SS_SUM_BIT    7
`define FSR_SC_RXEN_BIT   0
`define FSR_SC_TXEN_BIT   1
`define FSR_SC_RXIE_BIT   2
`define FSR_SC_TXIE_BIT   3
`define FSR_SC_GIE_BIT    4
`define FSR_SC_RXCLR_BIT  5
`define FSR_SC_BAUD_LO    6
`define FSR_U2_FVIE_BIT   3
`define FSR_RESET_BYTE    8'h00
// ==========================================================
// Timing: core clock rate and the fixed baud set
`define FSR_CLK_HZ   250000000
`define FSR_BAUD_0   9600
`define FSR_BAUD_1   19200
`define FSR_BAUD_2   38400
`define FSR_BAUD_3   115200
`endif

// *** src/fsr_pkg.sv ***
package fsr_pkg;
   // Serial shifter phases
   typedef enum logic [1:0] {FSR_IDLE, FSR_START, FSR_DATA, FSR_STOP} fsr_uart_state_t;
endpackage

// *** src/fsr_host_regs.sv ***
`timescale 1ns/1ps
`include "fsr_cfg.svh"
module fsr_host_regs #(
   parameter int BIT_CYC_0 = `FSR_CLK_HZ / `FSR_BAUD_0,   // Cycles per bit at 9600
   parameter int BIT_CYC_1 = `FSR_CLK_HZ / `FSR_BAUD_1,   // Cycles per bit at 19200
   parameter int BIT_CYC_2 = `FSR_CLK_HZ / `FSR_BAUD_2,   // Cycles per bit at 38400
   parameter int BIT_CYC_3 = `FSR_CLK_HZ / `FSR_BAUD_3    // Cycles per bit at 115200
) (
   input  wire logic       clk_in,                 // Core clock, 250 MHz
   input  wire logic       reset_in,               // Synchronous reset, active high
   input  wire logic       psel_in,                // APB select
   input  wire logic       penable_in,             // APB enable
   input  wire logic       pwrite_in,              // APB write
   input  wire logic [7:0] paddr_in,               // APB byte address
   input  wire logic [31:0] pwdata_in,             // APB write data
   output logic            pready_out,             // APB ready
   output logic            pslverr_out,            // APB error on unmapped index
   output logic [31:0]     prdata_out,             // APB read data
   input  wire logic       fifo_has_data_in,       // Output FIFO holds DMA data
   input  wire logic       fifo_underrun_in,       // FIFO ran dry while needed
   input  wire logic       frame_valid_in,         // Frame-valid toward grabber
   output logic            sim_clear_out,          // Hold simulator cleared
   input  wire logic [3:0] cam_ctrl_lines_in,      // Control lines from grabber
   input  wire logic       serial_from_grabber_in, // Serial input pin
   output logic            serial_to_grabber_out,  // Serial output pin
   output logic            summary_irq_out         // Summary interrupt level
);
   // ==========================================================
   // Bus decode
   wire [5:0] idx      = paddr_in[7:2];
   wire       setup    = psel_in & ~penable_in;
   wire       access   = psel_in & penable_in;
   wire       wr       = access & pwrite_in;
   wire       rd_acc   = access & ~pwrite_in;
   wire [7:0] wbyte    = pwdata_in[7:0];
   wire       hit_cmd  = idx == `FSR_IDX_CMD;
   wire       hit_stat = idx == `FSR_IDX_STAT;
   wire       hit_cfg  = idx == `FSR_IDX_CFG;
   wire       hit_rsvd = idx == `FSR_IDX_RSVD;
   wire       hit_mode = idx == `FSR_IDX_MODE;
   wire       hit_sdat = idx == `FSR_IDX_SDATA;
   wire       hit_ss   = idx == `FSR_IDX_SSTAT;
   wire       hit_sctl = idx == `FSR_IDX_SCTL;
   wire       hit_u2   = idx == `FSR_IDX_UTIL2;
   wire       mapped   = hit_cmd | hit_stat | hit_cfg | hit_rsvd | hit_mode |
                         hit_sdat | hit_ss | hit_sctl | hit_u2;
   // Zero wait states; the read byte is captured in the setup cycle
   assign pready_out  = 1'b1;
   assign pslverr_out = access & ~mapped;

   // ==========================================================
   // Host-written state
   logic [7:0] cfg_reg;
   logic [7:0] sctl_reg;
   logic [7:0] util2_reg;
   wire        sim_clear   = cfg_reg[`FSR_CFG_CLR_BIT];
   wire        clr_cmd     = wr & hit_cmd & wbyte[`FSR_CMD_CLR_BIT];
   wire        rst_cmd     = wr & hit_cmd & wbyte[`FSR_CMD_RST_BIT];
   wire        rx_flag_clear = wr & hit_sctl & wbyte[`FSR_SC_RXCLR_BIT];
   wire        global_irq_enable = sctl_reg[`FSR_SC_GIE_BIT];
   wire        frame_irq_enable  = util2_reg[`FSR_U2_FVIE_BIT];
   assign sim_clear_out = sim_clear;

   // Configuration, serial control and utility registers
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         cfg_reg   <= `FSR_RESET_BYTE;
         sctl_reg  <= `FSR_RESET_BYTE;
         util2_reg <= `FSR_RESET_BYTE;
      end
      else
      begin
         if (wr & hit_cfg)
            cfg_reg <= wbyte;
         // Bit 5 is a strobe and never stored
         if (wr & hit_sctl)
            sctl_reg <= wbyte & ~(8'h01 << `FSR_SC_RXCLR_BIT);
         if (wr & hit_u2)
            util2_reg <= wbyte;
      end
   end

   // ==========================================================
   // Synchronisers for pins
   logic       fv_s1_reg, fv_s2_reg, fv_s3_reg;
   logic       ser_s1_reg, ser_s2_reg;
   logic [3:0] cc_s1_reg, cc_s2_reg;
   always_ff @(posedge clk_in)
   begin
      fv_s1_reg  <= frame_valid_in;
      fv_s2_reg  <= fv_s1_reg;
      fv_s3_reg  <= fv_s2_reg;
      ser_s1_reg <= serial_from_grabber_in;
      ser_s2_reg <= ser_s1_reg;
      cc_s1_reg  <= cam_ctrl_lines_in;
      cc_s2_reg  <= cc_s1_reg;
   end
   wire fv_rise = fv_s2_reg & ~fv_s3_reg;

   // ==========================================================
   // Frame-edge flag and underrun; a new edge beats a clear command
   logic frame_edge_latched_reg;
   logic underrun_reg;
   always_ff @(posedge clk_in)
   begin
      if (reset_in | sim_clear)
      begin
         frame_edge_latched_reg <= 1'b0;
         underrun_reg           <= 1'b0;
      end
      else
      begin
         if (fv_rise)
            frame_edge_latched_reg <= 1'b1;
         else if (clr_cmd | rst_cmd)
            frame_edge_latched_reg <= 1'b0;
         if (fifo_underrun_in)
            underrun_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Baud select; no programmable rate, so the fixed set always applies
   wire [1:0]  baud_sel = sctl_reg[`FSR_SC_BAUD_LO +: 2];
   wire [15:0] bit_cyc  = (baud_sel == 2'd0) ? 16'(BIT_CYC_0) :
                          (baud_sel == 2'd1) ? 16'(BIT_CYC_1) :
                          (baud_sel == 2'd2) ? 16'(BIT_CYC_2) : 16'(BIT_CYC_3);

   // ==========================================================
   // Transmitter: holding register feeding an 8N1 shifter
   fsr_pkg::fsr_uart_state_t tx_state_reg;
   logic [7:0]  tx_hold_reg, tx_shift_reg;
   logic        tx_full_reg;
   logic [15:0] tx_cnt_reg;
   logic [2:0]  tx_idx_reg;
   logic        tx_line_reg;
   wire tx_en   = sctl_reg[`FSR_SC_TXEN_BIT];
   wire tx_tick = tx_cnt_reg == bit_cyc - 16'd1;
   wire tx_load = (tx_state_reg == fsr_pkg::FSR_IDLE) & tx_full_reg & tx_en;
   wire tx_wr   = wr & hit_sdat;
   assign serial_to_grabber_out = tx_line_reg;

   // Holding register; a write while full overwrites the pending byte
   always_ff @(posedge clk_in)
   begin
      if (reset_in | sim_clear)
         tx_full_reg <= 1'b0;
      else if (tx_wr)
         tx_full_reg <= 1'b1;
      else if (tx_load)
         tx_full_reg <= 1'b0;
      if (tx_wr)
         tx_hold_reg <= wbyte;
   end

   // Shifter, line idles high; start, eight bits LSB first, stop
   always_ff @(posedge clk_in)
   begin
      if (reset_in | sim_clear)
      begin
         tx_state_reg <= fsr_pkg::FSR_IDLE;
         tx_line_reg  <= 1'b1;
         tx_cnt_reg   <= 16'h0000;
         tx_idx_reg   <= 3'h0;
         tx_shift_reg <= 8'h00;
      end
      else
      begin
         tx_cnt_reg <= (tx_tick | tx_load) ? 16'h0000 : tx_cnt_reg + 16'd1;
         case (tx_state_reg)
            fsr_pkg::FSR_IDLE:
               if (tx_load)
               begin
                  tx_shift_reg <= tx_hold_reg;
                  tx_line_reg  <= 1'b0;
                  tx_state_reg <= fsr_pkg::FSR_START;
               end
            fsr_pkg::FSR_START:
               if (tx_tick)
               begin
                  tx_line_reg  <= tx_shift_reg[0];
                  tx_idx_reg   <= 3'h0;
                  tx_state_reg <= fsr_pkg::FSR_DATA;
               end
            fsr_pkg::FSR_DATA:
               if (tx_tick)
               begin
                  if (tx_idx_reg == 3'h7)
                  begin
                     tx_line_reg  <= 1'b1;
                     tx_state_reg <= fsr_pkg::FSR_STOP;
                  end
                  else
                  begin
                     tx_line_reg  <= tx_shift_reg[tx_idx_reg + 3'h1];
                     tx_idx_reg   <= tx_idx_reg + 3'h1;
                  end
               end
            fsr_pkg::FSR_STOP:
               if (tx_tick)
                  tx_state_reg <= fsr_pkg::FSR_IDLE;
            default:
               tx_state_reg <= fsr_pkg::FSR_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Receiver: start found on the falling line, sampled mid-bit
   fsr_pkg::fsr_uart_state_t rx_state_reg;
   logic [15:0] rx_cnt_reg;
   logic [2:0]  rx_idx_reg;
   logic [7:0]  rx_shift_reg, rx_data_reg;
   logic        rx_rdy_reg;
   wire rx_en    = sctl_reg[`FSR_SC_RXEN_BIT];
   wire rx_tick  = rx_cnt_reg == bit_cyc - 16'd1;
   wire rx_mid   = rx_cnt_reg == (bit_cyc >> 1);
   wire rx_done  = (rx_state_reg == fsr_pkg::FSR_STOP) & rx_mid & ser_s2_reg;
   wire rx_taken = rd_acc & hit_sdat;
   always_ff @(posedge clk_in)
   begin
      if (reset_in | sim_clear)
      begin
         rx_state_reg <= fsr_pkg::FSR_IDLE;
         rx_cnt_reg   <= 16'h0000;
         rx_idx_reg   <= 3'h0;
         rx_shift_reg <= 8'h00;
      end
      else
      begin
         rx_cnt_reg <= (rx_tick | rx_state_reg == fsr_pkg::FSR_IDLE) ? 16'h0000
                       : rx_cnt_reg + 16'd1;
         case (rx_state_reg)
            fsr_pkg::FSR_IDLE:
               if (rx_en & ~ser_s2_reg)
                  rx_state_reg <= fsr_pkg::FSR_START;
            fsr_pkg::FSR_START:
               // A glitch shorter than half a bit is dropped
               if (rx_mid & ser_s2_reg)
                  rx_state_reg <= fsr_pkg::FSR_IDLE;
               else if (rx_tick)
               begin
                  rx_idx_reg   <= 3'h0;
                  rx_state_reg <= fsr_pkg::FSR_DATA;
               end
            fsr_pkg::FSR_DATA:
            begin
               if (rx_mid)
                  rx_shift_reg <= {ser_s2_reg, rx_shift_reg[7:1]};
               if (rx_tick)
               begin
                  rx_idx_reg <= rx_idx_reg + 3'h1;
                  if (rx_idx_reg == 3'h7)
                     rx_state_reg <= fsr_pkg::FSR_STOP;
               end
            end
            fsr_pkg::FSR_STOP:
               if (rx_mid)
                  rx_state_reg <= fsr_pkg::FSR_IDLE;   // Bad stop bit drops byte
            default:
               rx_state_reg <= fsr_pkg::FSR_IDLE;
         endcase
      end
   end

   // Received byte and its ready flag; a new byte beats a clear
   always_ff @(posedge clk_in)
   begin
      if (reset_in | sim_clear)
      begin
         rx_rdy_reg  <= 1'b0;
         rx_data_reg <= 8'h00;
      end
      else if (rx_done)
      begin
         rx_rdy_reg  <= 1'b1;
         rx_data_reg <= rx_shift_reg;
      end
      else if (rx_flag_clear | rx_taken)
         rx_rdy_reg <= 1'b0;
   end

   // ==========================================================
   // Interrupt summary and status bytes
   wire tx_ready       = ~tx_full_reg;
   wire frame_edge_irq = frame_edge_latched_reg & frame_irq_enable;
   wire summary_irq    = global_irq_enable &
                         (frame_edge_irq |
                          (tx_ready & sctl_reg[`FSR_SC_TXIE_BIT]) |
                          (rx_rdy_reg & sctl_reg[`FSR_SC_RXIE_BIT]));
   wire [7:0] stat_byte = ({7'h00, underrun_reg} << `FSR_ST_UNDER_BIT) |
                          ({7'h00, fv_s2_reg} << `FSR_ST_FV_BIT) |
                          ({7'h00, fifo_has_data_in} << `FSR_ST_FIFO_BIT);
   wire [7:0] ss_byte   = ({7'h00, rx_rdy_reg} << `FSR_SS_RXRDY_BIT) |
                          ({7'h00, tx_ready} << `FSR_SS_TXRDY_BIT) |
                          ({7'h00, frame_edge_irq} << `FSR_SS_FVIRQ_BIT) |
                          ({7'h00, frame_edge_latched_reg} << `FSR_SS_FVLAT_BIT) |
                          ({7'h00, summary_irq} << `FSR_SS_SUM_BIT);
   wire [7:0] rd_byte   = hit_cmd  ? `FSR_CMD_READBACK :
                          hit_stat ? stat_byte :
                          hit_cfg  ? cfg_reg :
                          hit_mode ? {4'h0, cc_s2_reg} :
                          hit_sdat ? rx_data_reg :
                          hit_ss   ? ss_byte :
                          hit_sctl ? sctl_reg :
                          hit_u2   ? util2_reg : 8'h00;

   // Read data and interrupt output from flip-flops
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         prdata_out      <= 32'h00000000;
         summary_irq_out <= 1'b0;
      end
      else
      begin
         if (setup & ~pwrite_in)
            prdata_out <= {24'h000000, rd_byte};
         summary_irq_out <= summary_irq;
      end
   end

   // ==========================================================
   // Assertions
   property p_cmd_reads;
      @(posedge clk_in) disable iff (reset_in)
      rd_acc & hit_cmd |-> prdata_out[7:0] == `FSR_CMD_READBACK;
   endproperty
   a_cmd_reads: assert property (p_cmd_reads) else $error("Command readback wrong");

   property p_clr_cmd;
      @(posedge clk_in) disable iff (reset_in)
      clr_cmd & ~fv_rise |=> ~frame_edge_latched_reg;
   endproperty
   a_clr_cmd: assert property (p_clr_cmd) else $error("Clear command ignored");

   property p_rst_cmd;
      @(posedge clk_in) disable iff (reset_in)
      rst_cmd & ~fv_rise |=>
         ~frame_edge_latched_reg ##1 (~frame_edge_latched_reg || $past(fv_rise));
   endproperty
   a_rst_cmd: assert property (p_rst_cmd) else $error("Reset command ignored");

   property p_fifo_flag;
      @(posedge clk_in) disable iff (reset_in)
      setup & ~pwrite_in & hit_stat |=>
         prdata_out[`FSR_ST_FIFO_BIT] == $past(fifo_has_data_in);
   endproperty
   a_fifo_flag: assert property (p_fifo_flag) else $error("FIFO flag wrong");

   property p_sim_clear;
      @(posedge clk_in) disable iff (reset_in)
      sim_clear ##1 sim_clear |-> ~frame_edge_latched_reg & ~rx_rdy_reg & tx_line_reg;
   endproperty
   a_sim_clear: assert property (p_sim_clear) else $error("Clear hold failed");

   property p_rsvd;
      @(posedge clk_in) disable iff (reset_in)
      rd_acc & hit_rsvd |-> prdata_out == 32'h00000000 && !pslverr_out;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("Reserved read not zero");

   property p_edge_latch;
      @(posedge clk_in) disable iff (reset_in)
      $rose(fv_s2_reg) & ~sim_clear |=> frame_edge_latched_reg;
   endproperty
   a_edge_latch: assert property (p_edge_latch) else $error("Edge not latched");

   property p_gie;
      @(posedge clk_in) disable iff (reset_in)
      ~global_irq_enable |=> ~summary_irq_out;
   endproperty
   a_gie: assert property (p_gie) else $error("Interrupt without enable");

   property p_fvirq;
      @(posedge clk_in) disable iff (reset_in)
      frame_edge_latched_reg & frame_irq_enable & global_irq_enable |=> summary_irq_out;
   endproperty
   a_fvirq: assert property (p_fvirq) else $error("Frame interrupt missing");

   property p_tx_start;
      @(posedge clk_in) disable iff (reset_in | sim_clear)
      tx_load |=> ~serial_to_grabber_out [*2];
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("No start bit");

   c_edge: cover property (@(posedge clk_in) fv_rise ##1 clr_cmd);
   c_rx:   cover property (@(posedge clk_in) rx_done);
   c_tx:   cover property (@(posedge clk_in) tx_load);
endmodule // fsr_host_regs

// *** sim/fsr_grabber_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Frame grabber side: control lines and 8N1 serial link
module fsr_grabber_model #(
   parameter int BIT_CYC = 16               // Cycles per serial bit
) (
   input  wire logic       clk_in,          // Core clock
   input  wire logic [3:0] cam_set_in,      // Wanted control line levels
   input  wire logic       send_in,         // Start one serial frame
   input  wire logic [7:0] send_byte_in,    // Byte to send
   input  wire logic       serial_in,       // Line from the device
   output logic            serial_out,      // Line to the device
   output logic [3:0]      cam_lines_out,   // Control lines to the device
   output logic [7:0]      rx_byte_out,     // Last byte received
   output logic            rx_valid_out     // One-cycle pulse per byte
);
   logic [7:0] sb;
   logic [7:0] rb;
   initial
   begin
      serial_out = 1'b1;
      cam_lines_out = 4'h0;
      rx_byte_out = 8'h00;
      rx_valid_out = 1'b0;
   end
   // Control lines follow the bench one cycle late, like a cable
   always @(posedge clk_in)
   begin
      cam_lines_out <= cam_set_in;
   end
   // Sender: start bit, data LSB first, stop bit, then idle high
   always
   begin
      do @(posedge clk_in); while (send_in !== 1'b1);
      sb = send_byte_in;
      serial_out <= 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         repeat (BIT_CYC) @(posedge clk_in);
         serial_out <= (i < 8) ? sb[i] : 1'b1;
      end
      repeat (BIT_CYC) @(posedge clk_in);
   end
   // Receiver samples mid-bit; a bad stop bit drops the byte
   always
   begin
      @(negedge serial_in);
      repeat (BIT_CYC / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CYC) @(posedge clk_in);
         rb[i] = serial_in;
      end
      repeat (BIT_CYC) @(posedge clk_in);
      rx_byte_out <= rb;
      rx_valid_out <= serial_in;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
   end
endmodule // fsr_grabber_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin chk(nm, e, g); end
module testbench;
   logic clk_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0, sbyte = 0;
   logic [31:0] pwdata = 0;
   logic fifo = 0, und = 0, fv = 0, send = 0;
   logic [3:0] cam = 0, cam_w;
   logic ser_dn, ser_up, pready, perr, irq, clr, rxv;
   logic [31:0] prdata;
   logic [7:0] rxb;
   logic [15:0] lfsr = 16'd40925;
   logic [8:0] exp_rd[$];
   logic [7:0] exp_ser[$];
   int n_mismatch = 0, compares = 0, cyc = 0;
   // Only rate select 1 matches the model, so a wrong rate pick breaks the link
   fsr_host_regs #(.BIT_CYC_0(12), .BIT_CYC_1(16), .BIT_CYC_2(20), .BIT_CYC_3(24)) u_dut (
      .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
      .pslverr_out(perr), .prdata_out(prdata), .fifo_has_data_in(fifo),
      .fifo_underrun_in(und), .frame_valid_in(fv), .sim_clear_out(clr),
      .cam_ctrl_lines_in(cam_w), .serial_from_grabber_in(ser_up),
      .serial_to_grabber_out(ser_dn), .summary_irq_out(irq));
   fsr_grabber_model #(.BIT_CYC(16)) u_grab (
      .clk_in(clk_in), .cam_set_in(cam), .send_in(send), .send_byte_in(sbyte),
      .serial_in(ser_dn), .serial_out(ser_up), .cam_lines_out(cam_w),
      .rx_byte_out(rxb), .rx_valid_out(rxv));
   // ==========================================================
   // Clock, stimulus helpers
   initial
   begin
      forever #2 clk_in = ~clk_in;
   end
   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Each value is evaluated once, so a queue is popped only once per check
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
      @(posedge clk_in);
      penable <= 1;
      do @(posedge clk_in); while (pready !== 1'b1);
      psel <= 0; penable <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      exp_rd.push_back(e);
      apb(0, a, 8'h00);
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Result watchers take the oldest note when a result shows
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         n_mismatch++;
         close_out;
      end
      if (psel && penable && pready === 1'b1 && !pwrite)
         `CHK("read", exp_rd.pop_front(), {perr, prdata[7:0]})
      if (rxv === 1'b1)
         `CHK("serial", exp_ser.pop_front(), rxb)
   end
   // ==========================================================
   // Main sequence; register byte address is four times the index
   initial
   begin
      tick(20);
      reset_in <= 0;
      tick(2);
      apb(1, 8'h00, 8'h11);
      rd(8'h00, 9'h002);
      apb(1, 8'h14, 8'h00);
      rd(8'h14, 9'h000);
      rd(8'h3c, 9'h100);
      $display("map test done");
      // Status flags follow the inputs; underrun stays once seen
      for (int i = 0; i < 4; i++)
      begin
         lfsr = nxt(lfsr);
         fifo <= lfsr[0]; fv <= lfsr[1]; und <= (i == 2);
         tick(1);
         und <= 0;
         tick(6);
         rd(8'h04, {4'h0, lfsr[0], 2'b00, lfsr[1], i >= 2});
      end
      fifo <= 0; fv <= 0;
      apb(1, 8'h08, 8'h08);
      tick(2);
      `CHK("clear", 1'b1, clr)
      rd(8'h08, 9'h008);
      rd(8'h04, 9'h000);
      apb(1, 8'h08, 8'h00);
      tick(2);
      `CHK("clear", 1'b0, clr)
      for (int i = 0; i < 3; i++)
      begin
         lfsr = nxt(lfsr);
         cam <= lfsr[3:0];
         tick(6);
         rd(8'h1c, {5'h00, lfsr[3:0]});
      end
      $display("status test done");
      // Frame edge flag, its gating and both clear commands
      apb(1, 8'h40, 8'h08);
      apb(1, 8'h30, 8'h10);
      fv <= 1;
      tick(6);
      rd(8'h2c, 9'h0d2);
      tick(2);
      `CHK("irq", 1'b1, irq)
      apb(1, 8'h00, 8'h10);
      rd(8'h2c, 9'h002);
      for (int i = 0; i < 2; i++)
      begin
         fv <= 0;
         tick(6);
         fv <= 1;
         tick(6);
      end
      apb(1, 8'h00, 8'h01);
      rd(8'h2c, 9'h002);
      fv <= 0;
      tick(6);
      fv <= 1;
      tick(6);
      apb(1, 8'h30, 8'h00);
      rd(8'h2c, 9'h052);
      tick(2);
      `CHK("irq", 1'b0, irq)
      apb(1, 8'h40, 8'h00);
      rd(8'h2c, 9'h042);
      apb(1, 8'h00, 8'h10);
      $display("frame test done");
      // Transmit two bytes; the first waits in the holding register
      for (int i = 0; i < 2; i++)
      begin
         lfsr = nxt(lfsr);
         exp_ser.push_back(lfsr[7:0]);
         apb(1, 8'h28, lfsr[7:0]);
         if (i == 0) rd(8'h2c, 9'h000);
         apb(1, 8'h30, 8'h42);
         tick(190);
      end
      apb(1, 8'h30, 8'h5a);
      rd(8'h2c, 9'h082);
      $display("transmit test done");
      // Receive: ready flag, data, clear by read and by strobe
      apb(1, 8'h30, 8'h55);
      for (int i = 0; i < 2; i++)
      begin
         lfsr = nxt(lfsr);
         sbyte <= lfsr[7:0]; send <= 1;
         tick(1);
         send <= 0;
         tick(200);
         rd(8'h2c, 9'h083);
         if (i == 0) rd(8'h28, {1'b0, lfsr[7:0]});
         else apb(1, 8'h30, 8'h75);
         rd(8'h2c, 9'h002);
      end
      rd(8'h30, 9'h055);
      $display("receive test done");
      tick(4);
      close_out;
   end
endmodule // testbench
